// file: rtl/dpaoc_pkg.sv
// Shared constants and types for the dual converter output control block.
package dpaoc_pkg;
    localparam int RES_W     = 10;
    localparam int STAGES    = 9;
    localparam int ALIGN_D   = 3;
    localparam int MAX_AGE   = 3;
    localparam int BUF_DEPTH = 2;
    localparam int WARM_CYC  = 3;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] LAST_OFS = 8'h08;

    localparam int CTRL_FMT_BIT   = 0;
    localparam int CTRL_SLEEP_BIT = 1;
    localparam int CTRL_PD_BIT    = 2;
    localparam int CTRL_ODIS_BIT  = 3;
    localparam logic [3:0] CTRL_RESET = 4'h8;

    localparam int STAT_OVR_BIT   = 0;
    localparam int STAT_ACT_BIT   = 1;
    localparam int STAT_VALID_BIT = 2;
    localparam int STAT_LVL_LSB   = 4;
    localparam int LAST_B_LSB     = 16;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic [1:0] CODE_MAX      = 2'h2;
    localparam logic [1:0] CODE_BAD      = 2'h3;

    typedef logic [STAGES-1:0][1:0] dpaoc_codes_type;

    typedef struct packed {
        logic [RES_W-1:0] chan_a;
        logic [RES_W-1:0] chan_b;
    } dpaoc_word_type;
endpackage

// file: rtl/dpaoc_pair_buf.sv
// Small valid/ready buffer that holds result words between converter and output stage.
`timescale 1ns/1ps
`default_nettype none
module dpaoc_pair_buf #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [1:0]            level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
    } dpaoc_buf_type;

    dpaoc_buf_type state;
    dpaoc_buf_type next_state;
    logic          push;
    logic          pop;

    assign in_ready  = (state.count != CW'(DEPTH));
    assign out_valid = (state.count != '0);
    assign out_data  = state.mem[state.rd_ptr];
    assign level     = 2'(state.count);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_state = state;
        if (push) begin
            next_state.mem[state.wr_ptr] = in_data;
            next_state.wr_ptr = (state.wr_ptr == AW'(DEPTH - 1)) ? '0 : state.wr_ptr + AW'(1);
        end
        if (pop) begin
            next_state.rd_ptr = (state.rd_ptr == AW'(DEPTH - 1)) ? '0 : state.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            next_state.count = state.count + CW'(1);
        end else if (pop && !push) begin
            next_state.count = state.count - CW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

// file: rtl/dpaoc_top.sv
// Output control of a dual pipelined converter: stage alignment, correction, coding and drive.
//
// Behaviour
// R01: High format bit selects two's complement coding.
// R02: Sleep disables both channels, reference bias stays.
// R03: Power-down bit puts the device in power-down.
// R04: Output disable puts all result outputs high-impedance.
// R05: Each channel gives a 10-bit word, bit 9 MSB.
// R06: Result appears five clock cycles after its sample.
// R07: Samples advance one stage every half cycle.
// R08: Stage codes combined with overlap, no missing codes.
// R09: Sample on rising edge, valid on later edge.
// R10: Power-down with outputs driven holds last word.
// R11: Two's complement is offset binary, MSB inverted.
`timescale 1ns/1ps
`default_nettype none
module dpaoc_top (
    // Clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    // Stage decisions from and enables to the analog pipelines
    input  wire dpaoc_pkg::dpaoc_codes_type stage_code_a,
    input  wire dpaoc_pkg::dpaoc_codes_type stage_code_b,
    output logic                            chan_enable,
    output logic                            ref_bias_enable,
    // Three-state result outputs
    output logic [dpaoc_pkg::RES_W-1:0]     chan_a_result_bits,
    output logic                            chan_a_result_oe,
    output logic [dpaoc_pkg::RES_W-1:0]     chan_b_result_bits,
    output logic                            chan_b_result_oe,
    // Result handshake
    output logic                            result_valid,
    input  wire logic                       result_ready
);
    typedef struct packed {
        logic [3:0]                                  ctrl;
        logic                                        overrun;
        logic [31:0]                                 rdata;
        logic                                        wr_pend;
        logic [7:0]                                  wr_addr;
        logic [1:0]                                  warm;
        logic [dpaoc_pkg::ALIGN_D-1:0][dpaoc_pkg::STAGES-1:0][1:0] dly_a;
        logic [dpaoc_pkg::ALIGN_D-1:0][dpaoc_pkg::STAGES-1:0][1:0] dly_b;
        dpaoc_pkg::dpaoc_word_type                   out_word;
        logic                                        out_valid;
    } dpaoc_state_type;

    dpaoc_state_type            state;
    dpaoc_state_type            next_state;
    dpaoc_pkg::dpaoc_codes_type tap_a;
    dpaoc_pkg::dpaoc_codes_type tap_b;
    dpaoc_pkg::dpaoc_word_type  push_word;
    dpaoc_pkg::dpaoc_word_type  buf_word;
    logic                       fmt;
    logic                       sleep;
    logic                       pd;
    logic                       conv_active;
    logic                       push;
    logic                       buf_in_ready;
    logic                       buf_out_valid;
    logic                       load;
    logic                       take;
    logic [1:0]                 buf_level;

    // Each stage weighs one bit of overlap into the sum, so a comparator offset
    // that pushes one stage's code up is absorbed by the next stage's lower code.
    function automatic logic [dpaoc_pkg::RES_W-1:0] correct(input dpaoc_pkg::dpaoc_codes_type c);
        logic [dpaoc_pkg::RES_W:0] acc;
        logic [1:0]                d;
        acc = '0;
        for (int i = 0; i < dpaoc_pkg::STAGES - 1; i++) begin
            d   = (c[i] == dpaoc_pkg::CODE_BAD) ? dpaoc_pkg::CODE_MAX : c[i]; // R08
            acc = acc + ((dpaoc_pkg::RES_W + 1)'(d) << (dpaoc_pkg::STAGES - 1 - i)); // R08
        end
        acc = acc + (dpaoc_pkg::RES_W + 1)'(c[dpaoc_pkg::STAGES-1]);
        return acc[dpaoc_pkg::RES_W-1:0];
    endfunction

    // Stage k decides half a cycle after stage k-1; the final flash resolves with
    // stage 7, so the age in whole cycles is min(k/2, 3).
    function automatic int stage_delay(input int k);
        int age;
        age = ((k >> 1) > dpaoc_pkg::MAX_AGE) ? dpaoc_pkg::MAX_AGE : (k >> 1);
        return dpaoc_pkg::ALIGN_D - age;
    endfunction

    assign fmt             = state.ctrl[dpaoc_pkg::CTRL_FMT_BIT];
    assign sleep           = state.ctrl[dpaoc_pkg::CTRL_SLEEP_BIT];
    assign pd              = state.ctrl[dpaoc_pkg::CTRL_PD_BIT];
    assign conv_active     = !sleep && !pd;
    assign chan_enable     = conv_active; // R02 R03
    assign ref_bias_enable = !pd; // R02
    assign take            = hsel && hready && htrans == dpaoc_pkg::HTRANS_NONSEQ && hsize == dpaoc_pkg::HSIZE_WORD;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = state.rdata;

    generate
        for (genvar k = 0; k < dpaoc_pkg::STAGES; k++) begin : g_align
            if (stage_delay(k) == 0) begin : g_direct
                assign tap_a[k] = stage_code_a[k];
                assign tap_b[k] = stage_code_b[k];
            end else begin : g_delayed
                assign tap_a[k] = state.dly_a[stage_delay(k)-1][k]; // R07
                assign tap_b[k] = state.dly_b[stage_delay(k)-1][k]; // R07
            end
        end
    endgenerate

    assign push_word.chan_a = correct(tap_a); // R08
    assign push_word.chan_b = correct(tap_b); // R08
    assign push = conv_active && state.warm == 2'(dpaoc_pkg::WARM_CYC); // R02 R03

    dpaoc_pair_buf #(
        .WIDTH (2 * dpaoc_pkg::RES_W),
        .DEPTH (dpaoc_pkg::BUF_DEPTH)
    ) u_buf (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   (push_word),
        .out_valid (buf_out_valid),
        .out_ready (load), // R06
        .out_data  (buf_word),
        .level     (buf_level)
    );

    // While powered down the output word is frozen, so the pins keep the last result.
    assign load = buf_out_valid && (!state.out_valid || result_ready) && !pd; // R10

    always_comb begin
        next_state = state;
        next_state.dly_a[0] = stage_code_a; // R09
        next_state.dly_b[0] = stage_code_b; // R09
        for (int i = 1; i < dpaoc_pkg::ALIGN_D; i++) begin
            next_state.dly_a[i] = state.dly_a[i-1]; // R07
            next_state.dly_b[i] = state.dly_b[i-1]; // R07
        end
        // After wake-up the alignment line still holds stale decisions for a few cycles.
        if (!conv_active) begin
            next_state.warm = '0;
        end else if (state.warm != 2'(dpaoc_pkg::WARM_CYC)) begin
            next_state.warm = state.warm + 2'h1;
        end
        if (load) begin
            next_state.out_valid = 1'b1; // R09
            next_state.out_word  = buf_word; // R05
            if (fmt) begin
                next_state.out_word.chan_a[dpaoc_pkg::RES_W-1] = ~buf_word.chan_a[dpaoc_pkg::RES_W-1]; // R01 R11
                next_state.out_word.chan_b[dpaoc_pkg::RES_W-1] = ~buf_word.chan_b[dpaoc_pkg::RES_W-1]; // R01 R11
            end
        end else if (result_ready) begin
            next_state.out_valid = 1'b0;
        end
        next_state.wr_pend = take && hwrite;
        next_state.wr_addr = haddr[7:0];
        if (state.wr_pend && state.wr_addr == dpaoc_pkg::CTRL_OFS) begin
            next_state.ctrl = hwdata[3:0]; // R01 R02 R03 R04
        end
        if (state.wr_pend && state.wr_addr == dpaoc_pkg::STAT_OFS && hwdata[dpaoc_pkg::STAT_OVR_BIT]) begin
            next_state.overrun = 1'b0;
        end
        if (push && !buf_in_ready) begin
            next_state.overrun = 1'b1;
        end
        if (take && !hwrite) begin
            next_state.rdata = 32'h0;
            unique case (haddr[7:0])
                dpaoc_pkg::CTRL_OFS: begin
                    next_state.rdata[3:0] = next_state.ctrl;
                end
                dpaoc_pkg::STAT_OFS: begin
                    next_state.rdata[dpaoc_pkg::STAT_OVR_BIT]   = next_state.overrun;
                    next_state.rdata[dpaoc_pkg::STAT_ACT_BIT]   = conv_active;
                    next_state.rdata[dpaoc_pkg::STAT_VALID_BIT] = state.out_valid;
                    next_state.rdata[dpaoc_pkg::STAT_LVL_LSB +: 2] = buf_level;
                end
                dpaoc_pkg::LAST_OFS: begin
                    next_state.rdata[dpaoc_pkg::RES_W-1:0] = state.out_word.chan_a;
                    next_state.rdata[dpaoc_pkg::LAST_B_LSB +: dpaoc_pkg::RES_W] = state.out_word.chan_b;
                end
                default: begin
                    next_state.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= '0;
            state.ctrl <= dpaoc_pkg::CTRL_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign chan_a_result_bits = state.out_word.chan_a; // R05
    assign chan_b_result_bits = state.out_word.chan_b; // R05
    assign chan_a_result_oe   = !state.ctrl[dpaoc_pkg::CTRL_ODIS_BIT]; // R04
    assign chan_b_result_oe   = !state.ctrl[dpaoc_pkg::CTRL_ODIS_BIT]; // R04
    assign result_valid       = state.out_valid;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_fmt_offset: assert property (load && !fmt |=> chan_a_result_bits == $past(buf_word.chan_a)) // R01
        else $error("offset binary word differs from corrected word");
    chk_fmt_twos_msb: assert property (load && fmt |=>
        chan_b_result_bits == {~$past(buf_word.chan_b[9]), $past(buf_word.chan_b[8:0])}) // R11
        else $error("two's complement word is not MSB-inverted offset binary");
    chk_sleep_ref_on: assert property (sleep && !pd |-> !chan_enable && ref_bias_enable ##1 !push) // R02
        else $error("sleep did not disable channels with bias kept");
    chk_pd_no_push: assert property (pd |-> !chan_enable && !ref_bias_enable && !push) // R03
        else $error("converter active during power-down");
    chk_drive_write: assert property (state.wr_pend && state.wr_addr == dpaoc_pkg::CTRL_OFS
        ##0 hwdata[3] |=> !chan_a_result_oe && !chan_b_result_oe) // R04
        else $error("outputs still driven after disable written");
    chk_five_cycle: assert property (push && buf_in_ready && !buf_out_valid && !state.out_valid
        && !fmt ##1 !pd && !fmt |=> result_valid && chan_a_result_bits == $past(push_word.chan_a, 2)) // R06
        else $error("result did not arrive five cycles after its sample");
    chk_stage_age: assert property (tap_a[0] == $past(stage_code_a[0], 3) && tap_a[4] == $past(stage_code_a[4], 1)) // R07
        else $error("stage decisions misaligned");
    chk_mid_code: assert property (tap_b == {2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1}
        |-> push_word.chan_b == 10'h200) // R08
        else $error("overlap correction gives wrong code");
    chk_valid_edge: assert property (load && !fmt |=> result_valid && chan_b_result_bits == $past(buf_word.chan_b)) // R09
        else $error("loaded word not flagged valid");
    chk_pd_hold: assert property (pd && chan_a_result_oe |=> $stable(chan_a_result_bits) && $stable(chan_b_result_bits)) // R10
        else $error("output word changed during power-down");
endmodule
`default_nettype wire

// file: tb/dpaoc_capture_model.sv
// Receiving logic that takes both channel words from the three-state result pins.
`timescale 1ns/1ps
`default_nettype none
module dpaoc_capture_model (
    // Clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // Bench control
    input  wire logic                        stall,
    // Result pins
    input  wire logic [dpaoc_pkg::RES_W-1:0] a_bits,
    input  wire logic                        a_oe,
    input  wire logic [dpaoc_pkg::RES_W-1:0] b_bits,
    input  wire logic                        b_oe,
    // Handshake and captured view
    output logic                             result_ready,
    output logic [dpaoc_pkg::RES_W-1:0]      seen_a,
    output logic [dpaoc_pkg::RES_W-1:0]      seen_b
);
    logic [dpaoc_pkg::RES_W-1:0] last_a;
    logic [dpaoc_pkg::RES_W-1:0] last_b;

    // A released bus keeps no level, so the inverse shows up any read of an undriven pin.
    assign seen_a = a_oe ? a_bits : ~last_a;
    assign seen_b = b_oe ? b_bits : ~last_b;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ready <= 1'b0;
            last_a       <= '0;
            last_b       <= '0;
        end else begin
            result_ready <= !stall;
            if (a_oe)
                last_a <= a_bits;
            if (b_oe)
                last_b <= b_bits;
        end
    end
endmodule
`default_nettype wire

// file: tb/dual_pipelined_adc_output_control_tb.sv
// Self-checking bench for the dual converter output control block.
`timescale 1ns/1ps
`default_nettype none
module dual_pipelined_adc_output_control_tb;
    logic                       hclk, hresetn, hsel, hwrite, stall, mon_on, fmt_on;
    logic [31:0]                haddr, hwdata, rdv;
    logic [1:0]                 htrans;
    logic [2:0]                 hsize;
    wire logic                  hreadyout, hresp, chan_enable, ref_bias_enable, a_oe, b_oe;
    wire logic                  result_valid, result_ready;
    wire logic [31:0]           hrdata;
    wire logic [9:0]            a_bits, b_bits, seen_a, seen_b;
    dpaoc_pkg::dpaoc_codes_type code_a, code_b;
    logic [9:0]                 a0, b0;
    int                         cyc, tcount, err_total, check_count;

    dpaoc_top dpaoc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .stage_code_a(code_a), .stage_code_b(code_b),
        .chan_enable(chan_enable), .ref_bias_enable(ref_bias_enable), .chan_a_result_bits(a_bits),
        .chan_a_result_oe(a_oe), .chan_b_result_bits(b_bits), .chan_b_result_oe(b_oe),
        .result_valid(result_valid), .result_ready(result_ready));
    dpaoc_capture_model dpaoc_capture_model_inst (.hclk(hclk), .hresetn(hresetn), .stall(stall),
        .a_bits(a_bits), .a_oe(a_oe), .b_bits(b_bits), .b_oe(b_oe), .result_ready(result_ready),
        .seen_a(seen_a), .seen_b(seen_b));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // Stage code of sample n: channel B is offset so the two channels never match by accident.
    function automatic logic [1:0] code_of(input int n, input int k, input int b);
        return 2'((k == 8) ? (n + 2 * b) % 4 : (n + b) % 4);
    endfunction

    // Code 3 in a redundant stage counts as 2, the final flash keeps its full range.
    function automatic logic [9:0] word_of(input int n, input int b, input logic fmt);
        int s;
        logic [9:0] w;
        s = (n + b) % 4;
        if (s == 3)
            s = 2;
        w = 10'(s * 510 + (n + 2 * b) % 4);
        w[9] = w[9] ^ fmt;
        return w;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, addr};
        htrans <= dpaoc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= dpaoc_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic print_verdict();
        $display("Checks made: %0d, mismatches: %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Each stage sees its sample later the deeper it sits, as the analog pipeline delivers it.
    always @(posedge hclk) begin
        cyc = cyc + 1;
        // Codes stay at zero during reset, matching the cleared alignment line.
        for (int k = 0; k < 9 && hresetn; k++) begin
            code_a[k] <= code_of(cyc - ((k / 2 > 3) ? 3 : k / 2), k, 0);
            code_b[k] <= code_of(cyc - ((k / 2 > 3) ? 3 : k / 2), k, 1);
        end
        tcount++;
        if (tcount == 3000) begin
            err_total++;
            print_verdict();
        end
    end

    always @(negedge hclk) begin
        if (mon_on) begin
            chk(32'(result_valid), 32'h1, "result valid");
            chk(32'(seen_a), 32'(word_of(cyc - 5, 0, fmt_on)), "channel A word");
            chk(32'(seen_b), 32'(word_of(cyc - 5, 1, fmt_on)), "channel B word");
        end
    end

    task automatic watch(input int gap, input int len);
        repeat (gap) @(posedge hclk);
        mon_on = 1'b1;
        repeat (len) @(posedge hclk);
        mon_on = 1'b0;
    endtask

    task automatic test_reset();
        ahb(1'b0, dpaoc_pkg::CTRL_OFS, 32'h0, rdv);
        chk(rdv, 32'h00000008, "control after reset");
        chk(32'(hresp), 32'h0, "response okay");
        chk(32'({a_oe, b_oe, chan_enable, ref_bias_enable}), 32'h3, "pins after reset");
        ahb(1'b0, 8'h10, 32'h0, rdv);
        chk(rdv, 32'h0, "unmapped read");
    endtask

    task automatic test_stream();
        ahb(1'b1, dpaoc_pkg::CTRL_OFS, 32'h0, rdv);
        @(posedge hclk);
        chk(32'({a_oe, b_oe}), 32'h3, "outputs driven");
        watch(12, 20);
        ahb(1'b1, dpaoc_pkg::CTRL_OFS, 32'h1, rdv);
        repeat (8) @(posedge hclk);
        fmt_on = 1'b1;
        watch(0, 20);
        fmt_on = 1'b0;
        ahb(1'b1, dpaoc_pkg::CTRL_OFS, 32'h0, rdv);
    endtask

    task automatic test_stall_sleep();
        stall <= 1'b1;
        repeat (3) @(negedge hclk);
        a0 = seen_a;
        repeat (6) @(negedge hclk);
        chk(32'(seen_a), 32'(a0), "word held in stall");
        chk(32'(result_valid), 32'h1, "valid held in stall");
        @(posedge hclk);
        ahb(1'b1, dpaoc_pkg::CTRL_OFS, 32'h2, rdv);
        @(posedge hclk);
        chk(32'({chan_enable, ref_bias_enable}), 32'h1, "sleep enables");
        ahb(1'b0, dpaoc_pkg::STAT_OFS, 32'h0, rdv);
        chk(32'(rdv[5:0]), 32'h25, "overrun set, idle, word held, buffer full");
        stall <= 1'b0;
        repeat (8) @(posedge hclk);
        chk(32'(result_valid), 32'h0, "no words in sleep");
        ahb(1'b1, dpaoc_pkg::STAT_OFS, 32'h1, rdv);
        ahb(1'b0, dpaoc_pkg::STAT_OFS, 32'h0, rdv);
        chk(32'(rdv[0]), 32'h0, "overrun cleared");
        ahb(1'b1, dpaoc_pkg::CTRL_OFS, 32'h0, rdv);
        @(posedge hclk);
        chk(32'(chan_enable), 32'h1, "awake");
        watch(12, 10);
    endtask

    task automatic test_powerdown();
        ahb(1'b1, dpaoc_pkg::CTRL_OFS, 32'h4, rdv);
        @(posedge hclk);
        chk(32'({chan_enable, ref_bias_enable}), 32'h0, "power-down enables");
        @(negedge hclk);
        a0 = seen_a;
        b0 = seen_b;
        repeat (10) @(negedge hclk);
        chk(32'({a_oe, b_oe}), 32'h3, "outputs driven in power-down");
        chk(32'({seen_a, seen_b}), 32'({a0, b0}), "words frozen in power-down");
        @(posedge hclk);
        ahb(1'b0, dpaoc_pkg::LAST_OFS, 32'h0, rdv);
        chk(rdv, {6'h00, b0, 6'h00, a0}, "last word register");
        ahb(1'b1, dpaoc_pkg::CTRL_OFS, 32'hC, rdv);
        @(posedge hclk);
        chk(32'({a_oe, b_oe}), 32'h0, "outputs released");
        ahb(1'b1, dpaoc_pkg::CTRL_OFS, 32'h0, rdv);
        @(posedge hclk);
        chk(32'({a_oe, b_oe, ref_bias_enable}), 32'h7, "outputs driven again");
        watch(12, 10);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        stall = 1'b0;
        mon_on = 1'b0;
        fmt_on = 1'b0;
        cyc = 8;
        tcount = 0;
        err_total = 0;
        check_count = 0;
        code_a = '0;
        code_b = '0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset();
        test_stream();
        test_stall_sleep();
        test_powerdown();
        print_verdict();
    end
endmodule
`default_nettype wire
